// *** rtl/pi_map_pkg.sv ***
// Constants and carriers for the process image address mapper.
// Assumes one system clock; no software-visible registers.
package pi_map_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned WADDR_W = 16;
    localparam int unsigned MEM_AW = 9;
    localparam int unsigned MEM_WORDS = 512;
    localparam int unsigned BITS_PER_WORD = 16;
    localparam int unsigned BIT_IDX_W = 4;
    // ------------------------------------------------------------
    // Master address map
    // ------------------------------------------------------------
    localparam logic [15:0] IO_WORD_LIMIT = 16'h0100;
    localparam logic [15:0] VAR_WORD_FIRST = 16'h0100;
    localparam logic [15:0] VAR_WORD_LAST = 16'h01ff;
    localparam logic [15:0] VAR_BIT_FIRST = 16'h1000;
    localparam logic [15:0] VAR_BIT_LAST = 16'h1fff;
    localparam logic [15:0] IO_BIT_LIMIT = 16'h1000;
    localparam logic [15:0] READBACK_OFS = 16'h0200;
    localparam logic [15:0] RB_WORD_FIRST = 16'h0200;
    localparam logic [15:0] RB_WORD_LAST = 16'h02ff;
    // ------------------------------------------------------------
    // Kinds of access
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACC_WORD = 3'h0,
        ACC_BIT = 3'h1,
        ACC_BYTE = 3'h3,
        ACC_DWORD = 3'h2
    } acc_kind_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [3:0] bit_idx;
        logic [31:0] wdata;
    } plc_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic bit_access;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mst_req_s;

    typedef struct packed {
        logic valid;
        logic invalid;
        logic [31:0] rdata;
    } rsp_s;
endpackage

// *** rtl/process_image_mapper.sv ***
// Shared process image with a network-master port and a resident
// program port, both translated onto one word memory.
// Assumes both requesters sit on the same clock; one request per cycle each.
//
// What this block does
// - Master bit and word addresses in the first 256 words start at zero.
// - Master bit 4096 is word 256 bit 0; following bits count upward.
// - Master bit 8191 is word 511 bit 15, the range end.
// - Linear bit number equals word times sixteen plus bit position.
// - Program word access reaches the same word as the master's word address.
// - Program bit access uses zero-based word index plus bit index.
// - Program may also access bytes and double words.
// - High byte at twice word address, low byte at twice plus one.
// - Double-word address is word address halved, rounded down.
// - Shared variable data covers words 256 through 511.
// - Master read at output address plus 0x0200 returns output data.
`timescale 1ns/1ps
`default_nettype none
module process_image_mapper (
    input wire logic clock,
    input wire logic arst_n,
    input wire pi_map_pkg::mst_req_s mst_req,
    input wire pi_map_pkg::plc_req_s plc_req,
    input wire pi_map_pkg::acc_kind_e plc_kind,
    output pi_map_pkg::rsp_s mst_rsp,
    output pi_map_pkg::rsp_s plc_rsp
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Words 0..255 are I/O image, 256..511 the shared variables.
    logic [15:0] mem [pi_map_pkg::MEM_WORDS];

    // ------------------------------------------------------------
    // Master address decode
    // ------------------------------------------------------------
    logic m_ok;
    logic [8:0] m_word;
    logic [3:0] m_bit;
    logic [15:0] m_lin;

    always_comb begin
        m_ok = 1'b0;
        m_word = 9'h000;
        m_bit = 4'h0;
        m_lin = mst_req.addr;
        if (mst_req.bit_access) begin
            if (m_lin < pi_map_pkg::IO_BIT_LIMIT) begin
                // Bits of the I/O words count from zero
                m_ok = 1'b1;
                m_word = {1'b0, m_lin[11:4]};
                m_bit = m_lin[3:0];
            end else if (m_lin <= pi_map_pkg::VAR_BIT_LAST) begin
                // 4096 lands on word 256 bit 0, 8191 on word 511 bit 15
                m_ok = 1'b1;
                m_word = {1'b1, m_lin[11:4]};
                m_bit = m_lin[3:0];
            end
        end else begin
            if (m_lin <= pi_map_pkg::VAR_WORD_LAST) begin
                m_ok = 1'b1;
                m_word = m_lin[8:0];
            end else if (!mst_req.write
                         && m_lin >= pi_map_pkg::RB_WORD_FIRST
                         && m_lin <= pi_map_pkg::RB_WORD_LAST) begin
                // Read-back window mirrors the output words
                m_ok = 1'b1;
                m_word = 9'(m_lin - pi_map_pkg::READBACK_OFS);
            end
        end
    end

    // ------------------------------------------------------------
    // Program address decode
    // ------------------------------------------------------------
    logic p_ok;
    logic [8:0] p_word;
    logic [15:0] p_a;

    always_comb begin
        p_a = plc_req.addr;
        p_ok = 1'b0;
        p_word = 9'h000;
        case (plc_kind)
            pi_map_pkg::ACC_WORD, pi_map_pkg::ACC_BIT: begin
                // Same word numbering as the master
                p_ok = (p_a <= pi_map_pkg::VAR_WORD_LAST);
                p_word = p_a[8:0];
            end
            pi_map_pkg::ACC_BYTE: begin
                // Byte n lives in word n/2; even byte is the high half
                p_ok = (p_a[15:1] <= pi_map_pkg::VAR_WORD_LAST[14:0]);
                p_word = p_a[9:1];
            end
            pi_map_pkg::ACC_DWORD: begin
                // Double word n spans words 2n and 2n+1
                p_ok = (p_a <= (pi_map_pkg::VAR_WORD_LAST >> 1));
                p_word = {p_a[7:0], 1'b0};
            end
            default: begin
                p_ok = 1'b0;
                p_word = 9'h000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    pi_map_pkg::rsp_s next_mst_rsp, next_plc_rsp;
    logic [15:0] pw0, pw1;

    always_comb begin
        next_mst_rsp = '0;
        next_plc_rsp = '0;
        pw0 = mem[p_word];
        pw1 = mem[p_word + 9'h001];
        next_mst_rsp.valid = mst_req.valid;
        next_mst_rsp.invalid = mst_req.valid && !m_ok;
        if (mst_req.valid && m_ok) begin
            if (mst_req.bit_access)
                next_mst_rsp.rdata = {31'h0, mem[m_word][m_bit]};
            else
                next_mst_rsp.rdata = {16'h0, mem[m_word]};
        end
        next_plc_rsp.valid = plc_req.valid;
        next_plc_rsp.invalid = plc_req.valid && !p_ok;
        if (plc_req.valid && p_ok) begin
            case (plc_kind)
                pi_map_pkg::ACC_BIT:
                    next_plc_rsp.rdata = {31'h0, pw0[plc_req.bit_idx]};
                pi_map_pkg::ACC_BYTE:
                    next_plc_rsp.rdata = p_a[0] ? {24'h0, pw0[7:0]}
                                                : {24'h0, pw0[15:8]};
                pi_map_pkg::ACC_DWORD:
                    next_plc_rsp.rdata = {pw0, pw1};
                default:
                    next_plc_rsp.rdata = {16'h0, pw0};
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mst_rsp <= '0;
            plc_rsp <= '0;
        end else begin
            mst_rsp <= next_mst_rsp;
            plc_rsp <= next_plc_rsp;
        end
    end

    // ------------------------------------------------------------
    // Write planning
    // ------------------------------------------------------------
    // Every access becomes a masked word write, so bit and byte stores
    // never need a second write port; a double word adds one whole word.
    logic m_we;
    logic [15:0] m_mask;
    logic [15:0] m_data;
    logic [15:0] next_m_word;
    logic p_we0;
    logic p_we1;
    logic [8:0] p_word1;
    logic [15:0] p_mask;
    logic [15:0] p_data0;
    logic [15:0] p_data1;
    logic [15:0] next_p_word0;

    always_comb begin
        m_we = mst_req.valid && mst_req.write && m_ok;
        m_mask = 16'hffff;
        m_data = mst_req.wdata;
        if (mst_req.bit_access) begin
            // One bit of the word, picked by the linear bit number
            m_mask = 16'h0001 << m_bit;
            m_data = {16{mst_req.wdata[0]}};
        end
        next_m_word = (mem[m_word] & ~m_mask) | (m_data & m_mask);
        p_we0 = plc_req.valid && plc_req.write && p_ok;
        p_we1 = 1'b0;
        p_word1 = p_word + 9'h001;
        p_mask = 16'hffff;
        p_data0 = plc_req.wdata[15:0];
        p_data1 = plc_req.wdata[15:0];
        case (plc_kind)
            pi_map_pkg::ACC_BIT: begin
                // Word index plus bit index, both from zero
                p_mask = 16'h0001 << plc_req.bit_idx;
                p_data0 = {16{plc_req.wdata[0]}};
            end
            pi_map_pkg::ACC_BYTE: begin
                // Odd byte is the low half, even byte the high half
                p_mask = p_a[0] ? 16'h00ff : 16'hff00;
                p_data0 = {2{plc_req.wdata[7:0]}};
            end
            pi_map_pkg::ACC_DWORD: begin
                // High half to the even word, low half to the odd
                p_we1 = p_we0;
                p_data0 = plc_req.wdata[31:16];
            end
            default: begin
                p_mask = 16'hffff;
            end
        endcase
        next_p_word0 = (mem[p_word] & ~p_mask) | (p_data0 & p_mask);
    end

    // Memory contents carry no reset; the image is rebuilt at start-up.
    // Program stores come last, so the program wins a same-word clash.
    always_ff @(posedge clock) begin
        if (m_we) begin
            mem[m_word] <= next_m_word;
        end
        if (p_we0) begin
            mem[p_word] <= next_p_word0;
        end
        if (p_we1) begin
            mem[p_word1] <= p_data1;
        end
    end
endmodule
`default_nettype wire

// *** verification/process_image_mapper_chk.sv ***
// Port checker for the process image mapper.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module process_image_mapper_chk (
    input wire logic clock,
    input wire logic arst_n,
    input wire pi_map_pkg::mst_req_s mst_req,
    input wire pi_map_pkg::plc_req_s plc_req,
    input wire pi_map_pkg::acc_kind_e plc_kind,
    input wire pi_map_pkg::rsp_s mst_rsp,
    input wire pi_map_pkg::rsp_s plc_rsp
);
    logic bit_rq;
    logic word_rq;
    assign bit_rq = mst_req.valid && mst_req.bit_access;
    assign word_rq = mst_req.valid && !mst_req.bit_access;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_mst_answer: assert property (
        mst_req.valid |=> mst_rsp.valid) else $error("no master answer");
    a_plc_answer: assert property (
        plc_req.valid |=> plc_rsp.valid) else $error("no program answer");
    a_bit_mapped: assert property (
        bit_rq && mst_req.addr <= 16'h1fff |=> !mst_rsp.invalid)
        else $error("mapped bit refused");
    a_bit_beyond: assert property (
        bit_rq && mst_req.addr > 16'h1fff |=> mst_rsp.invalid)
        else $error("bit beyond range taken");
    a_word_beyond: assert property (
        word_rq && mst_req.addr > 16'h02ff |=> mst_rsp.invalid)
        else $error("word beyond range taken");
    a_void_data: assert property (
        mst_rsp.invalid |-> mst_rsp.rdata == 32'h0)
        else $error("refused answer carries data");
    a_dword_span: assert property (
        plc_req.valid && plc_kind == pi_map_pkg::ACC_DWORD |=>
        plc_rsp.invalid == ($past(plc_req.addr) > 16'h00ff))
        else $error("double word range wrong");
    a_byte_span: assert property (
        plc_req.valid && plc_kind == pi_map_pkg::ACC_BYTE |=>
        plc_rsp.invalid == ($past(plc_req.addr) > 16'h03ff))
        else $error("byte range wrong");
    a_mst_quiet: assert property (
        !mst_req.valid |=> !mst_rsp.valid)
        else $error("master answer unasked");
    a_rb_write: assert property (
        word_rq && mst_req.write && mst_req.addr >= 16'h0200
        && mst_req.addr <= 16'h02ff |=> mst_rsp.invalid)
        else $error("read-back write taken");
    a_plc_word: assert property (
        plc_req.valid && (plc_kind == pi_map_pkg::ACC_WORD
        || plc_kind == pi_map_pkg::ACC_BIT) |=>
        plc_rsp.invalid == ($past(plc_req.addr) > 16'h01ff))
        else $error("program word range wrong");
endmodule
bind process_image_mapper process_image_mapper_chk i_chk (.clock(clock),
    .arst_n(arst_n), .mst_req(mst_req), .plc_req(plc_req),
    .plc_kind(plc_kind), .mst_rsp(mst_rsp), .plc_rsp(plc_rsp));
`default_nettype wire

// *** verification/net_side_model.sv ***
// Network master and resident program, one request at a time each.
// Assumes the mapper answers one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none
module net_side_model (
    input wire logic clock,
    input wire pi_map_pkg::rsp_s mst_rsp,
    input wire pi_map_pkg::rsp_s plc_rsp,
    output var pi_map_pkg::mst_req_s mst_req,
    output var pi_map_pkg::plc_req_s plc_req,
    output var pi_map_pkg::acc_kind_e plc_kind
);
    initial begin
        mst_req = '0;
        plc_req = '0;
        plc_kind = pi_map_pkg::ACC_WORD;
    end
    // Released address and data lines are inverted so a stale value never looks live
    task automatic mst_op(input logic w, b, input logic [15:0] a, d,
        output pi_map_pkg::rsp_s r);
        @(posedge clock) #1 mst_req = '{1'b1, w, b, a, d};
        @(posedge clock) #1 mst_req = '{1'b0, w, b, ~a, ~d};
        r = mst_rsp;
    endtask
    task automatic plc_op(input pi_map_pkg::acc_kind_e k, input logic w,
        input logic [15:0] a, input logic [3:0] i, input logic [31:0] d,
        output pi_map_pkg::rsp_s r);
        @(posedge clock) #1 plc_req = '{1'b1, w, a, i, d};
        plc_kind = k;
        @(posedge clock) #1 plc_req = '{1'b0, w, ~a, ~i, ~d};
        r = plc_rsp;
    endtask
endmodule
`default_nettype wire

// *** verification/process_image_mapper_tb.sv ***
// Self-checking bench for the process image mapper.
// Assumes the mapper package and the network side model.
`timescale 1ns/1ps
`default_nettype none
module process_image_mapper_tb;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    pi_map_pkg::mst_req_s mst_req;
    pi_map_pkg::plc_req_s plc_req;
    pi_map_pkg::acc_kind_e plc_kind;
    pi_map_pkg::rsp_s mst_rsp;
    pi_map_pkg::rsp_s plc_rsp;
    pi_map_pkg::rsp_s r;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    always #50 clock = ~clock;
    process_image_mapper i_process_image_mapper (.clock(clock),
        .arst_n(arst_n), .mst_req(mst_req), .plc_req(plc_req),
        .plc_kind(plc_kind), .mst_rsp(mst_rsp), .plc_rsp(plc_rsp));
    net_side_model i_net_side_model (.clock(clock), .mst_rsp(mst_rsp),
        .plc_rsp(plc_rsp), .mst_req(mst_req), .plc_req(plc_req),
        .plc_kind(plc_kind));
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_flag(input string n, input logic e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", n, e, g);
        end
    endtask
    task automatic m(input logic w, b, input logic [15:0] a, d);
        i_net_side_model.mst_op(w, b, a, d, r);
        chk_flag("master answer", 1'h1, r.valid);
    endtask
    task automatic p(input pi_map_pkg::acc_kind_e k, input logic w,
        input logic [15:0] a, input logic [3:0] i, input logic [31:0] d);
        i_net_side_model.plc_op(k, w, a, i, d, r);
        chk_flag("program answer", 1'h1, r.valid);
    endtask
    task automatic t_shared();
        m(1'h1, 1'h0, 16'h0100, 16'h8001);
        p(pi_map_pkg::ACC_WORD, 1'h0, 16'h0100, 4'h0, 32'h0);
        chk("plc word", 32'h0000_8001, r.rdata);
        p(pi_map_pkg::ACC_BYTE, 1'h0, 16'h0201, 4'h0, 32'h0);
        chk("low byte", 32'h0000_0001, r.rdata);
        p(pi_map_pkg::ACC_BYTE, 1'h0, 16'h0200, 4'h0, 32'h0);
        chk("high byte", 32'h0000_0080, r.rdata);
        m(1'h0, 1'h1, 16'h1000, 16'h0000);
        chk("bit 4096", 32'h1, r.rdata);
        m(1'h0, 1'h1, 16'h1001, 16'h0000);
        chk("bit 4097", 32'h0, r.rdata);
    endtask
    task automatic t_bits();
        p(pi_map_pkg::ACC_WORD, 1'h1, 16'h01ff, 4'h0, 32'h0000_8000);
        m(1'h0, 1'h1, 16'h1fff, 16'h0000);
        chk("bit 8191", 32'h1, r.rdata);
        p(pi_map_pkg::ACC_WORD, 1'h1, 16'h0001, 4'h0, 32'h0);
        m(1'h1, 1'h1, 16'h0013, 16'h0001);
        p(pi_map_pkg::ACC_BIT, 1'h0, 16'h0001, 4'h3, 32'h0);
        chk("plc bit", 32'h1, r.rdata);
        m(1'h0, 1'h0, 16'h0001, 16'h0000);
        chk("word 1", 32'h0000_0008, r.rdata);
        p(pi_map_pkg::ACC_WORD, 1'h1, 16'h00ff, 4'h0, 32'h0);
        m(1'h1, 1'h1, 16'h0fff, 16'h0001);
        chk_flag("bit 4095 taken", 1'h0, r.invalid);
        p(pi_map_pkg::ACC_WORD, 1'h0, 16'h00ff, 4'h0, 32'h0);
        chk("word 255", 32'h0000_8000, r.rdata);
        p(pi_map_pkg::ACC_BIT, 1'h1, 16'h00ff, 4'h0, 32'h1);
        m(1'h0, 1'h0, 16'h00ff, 16'h0000);
        chk("plc bit store", 32'h0000_8001, r.rdata);
    endtask
    task automatic t_wide();
        p(pi_map_pkg::ACC_DWORD, 1'h1, 16'h0080, 4'h0, 32'hdead_beef);
        m(1'h0, 1'h0, 16'h0100, 16'h0000);
        chk("dword high", 32'h0000_dead, r.rdata);
        m(1'h0, 1'h0, 16'h0101, 16'h0000);
        chk("dword low", 32'h0000_beef, r.rdata);
        p(pi_map_pkg::ACC_DWORD, 1'h0, 16'h0080, 4'h0, 32'h0);
        chk("dword read", 32'hdead_beef, r.rdata);
        p(pi_map_pkg::ACC_BYTE, 1'h1, 16'h03ff, 4'h0, 32'h0000_005a);
        m(1'h0, 1'h0, 16'h01ff, 16'h0000);
        chk("byte 1023", 32'h0000_805a, r.rdata);
        p(pi_map_pkg::ACC_BYTE, 1'h1, 16'h03fe, 4'h0, 32'h0000_0011);
        m(1'h0, 1'h0, 16'h01ff, 16'h0000);
        chk("byte 1022", 32'h0000_115a, r.rdata);
    endtask
    task automatic t_refuse();
        m(1'h1, 1'h0, 16'h0005, 16'h00a5);
        m(1'h1, 1'h0, 16'h0205, 16'h1111);
        chk_flag("echo write", 1'h1, r.invalid);
        m(1'h0, 1'h0, 16'h0205, 16'h0000);
        chk("echo read", 32'h0000_00a5, r.rdata);
        m(1'h0, 1'h1, 16'h2000, 16'h0000);
        chk_flag("bit 8192", 1'h1, r.invalid);
        chk("refused data", 32'h0, r.rdata);
        m(1'h1, 1'h0, 16'h0000, 16'h00c3);
        p(pi_map_pkg::ACC_DWORD, 1'h1, 16'h0100, 4'h0, 32'h1234_5678);
        chk_flag("dword 256", 1'h1, r.invalid);
        p(pi_map_pkg::ACC_WORD, 1'h1, 16'h0200, 4'h0, 32'h0000_0001);
        chk_flag("word 512", 1'h1, r.invalid);
        m(1'h0, 1'h0, 16'h0000, 16'h0000);
        chk("word 0 kept", 32'h0000_00c3, r.rdata);
        m(1'h0, 1'h0, 16'h0001, 16'h0000);
        chk("word 1 kept", 32'h0000_0008, r.rdata);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        #1 arst_n = 1'b1;
        t_shared();
        t_bits();
        t_wide();
        t_refuse();
        print_verdict();
    end
endmodule
`default_nettype wire
